// ---- rtl/mba_access.sv ----
// How it works
// - Function 3 reads up to 45 registers
// - Function 6 stores one 16-bit value
// - Function 16 writes up to 45 registers
// - Function 23 writes then reads, 45 each
// - Every array register holds 16 readable/writable bits
// - Assembly access not at first register errors
// - Numbering one-based; register zero does not exist
// - All protocols share one register array
// - Scattered registers appear as contiguous assemblies
// - Hand-over value in mailbox starts conveying
// - Three protocols; native one serves neighbours
// - Exactly one response per request
`include "mba_cfg.svh"
`default_nettype none
module mba_access #(
	parameter int DEPTH = `MBA_DEPTH
) (
	input  wire logic             sys_clk,
	input  wire logic             rst_b,
	input  wire logic             req_valid,
	output logic                  req_ready,
	input  wire mba_pkg::mba_req_t req,
	input  wire logic             wr_valid,
	output logic                  wr_ready,
	input  wire logic [15:0]      wr_data,
	output logic                  rd_valid,
	input  wire logic             rd_ready,
	output logic [15:0]           rd_data,
	output logic                  resp_valid,
	input  wire logic             resp_ready,
	output mba_pkg::mba_resp_t    resp,
	output logic                  handover_pulse
);

	localparam int AW = $clog2(DEPTH);

	mba_pkg::mba_state_t state_q;
	mba_pkg::mba_req_t   req_q;
	mba_pkg::mba_resp_t  resp_q;
	logic [7:0]          idx_q;
	logic [7:0]          w_cnt_q;
	logic [7:0]          r_cnt_q;
	logic                rd_valid_q;
	logic [15:0]         rd_data_q;
	logic                ho_q;
	logic [15:0]         mem [DEPTH];

	logic [7:0]          w_cnt_c;
	logic [7:0]          r_cnt_c;
	logic                fc_ok_c;
	logic                cnt_bad_c;
	logic                addr_bad_c;
	logic                exc_c;
	logic [7:0]          exc_code_c;
	logic [15:0]         wphys_c;
	logic [AW-1:0]       waddr_c;
	logic [AW-1:0]       raddr_c;
	logic                wr_fire;
	logic                rd_fire;

	// Assembly windows fold onto scattered source registers
	function automatic logic [15:0] phys(input logic [15:0] a);
		logic [15:0] off;
		off = 16'h0000;
		if (a >= `MBA_IN_BASE && a < `MBA_IN_BASE + `MBA_IN_LEN) begin
			off = (a - `MBA_IN_BASE) * `MBA_IN_STRIDE;
			return `MBA_IN_SRC + off;
		end
		if (a >= `MBA_OUT_BASE && a < `MBA_OUT_BASE + `MBA_OUT_LEN) begin
			off = (a - `MBA_OUT_BASE) * `MBA_OUT_STRIDE;
			return `MBA_OUT_SRC + off;
		end
		return a;
	endfunction : phys

	function automatic logic range_bad(input logic [15:0] s, input logic [7:0] c);
		logic [16:0] last;
		last = {1'b0, s} + {9'h000, c} - 17'h00001;
		return (s == 16'h0000) || (last > 17'(DEPTH));
	endfunction : range_bad

	function automatic logic asm_bad(input logic [15:0] s);
		return (s > `MBA_IN_BASE && s < `MBA_IN_BASE + `MBA_IN_LEN) ||
			(s > `MBA_OUT_BASE && s < `MBA_OUT_BASE + `MBA_OUT_LEN);
	endfunction : asm_bad

	function automatic logic cnt_bad(input logic [7:0] c);
		return (c == 8'h00) || (c > `MBA_MAX_CNT);
	endfunction : cnt_bad

	always_comb begin
		// Any of the three protocols reaches the same array
		fc_ok_c = (req_q.proto == mba_pkg::MBA_PROTO_MODBUS) || (req_q.proto == mba_pkg::MBA_PROTO_ENIP) ||
			(req_q.proto == mba_pkg::MBA_PROTO_PNIO);
		w_cnt_c = 8'h00;
		r_cnt_c = 8'h00;
		cnt_bad_c = 1'b0;
		addr_bad_c = 1'b0;
		case (req_q.func)
			`MBA_FC_READ: begin
				r_cnt_c = req_q.rd_cnt;
			end
			`MBA_FC_WRITE1: begin
				w_cnt_c = 8'h01;
			end
			`MBA_FC_WRITEN: begin
				w_cnt_c = req_q.wr_cnt;
			end
			`MBA_FC_RDWR: begin
				w_cnt_c = req_q.wr_cnt;
				r_cnt_c = req_q.rd_cnt;
			end
			default: begin
				fc_ok_c = 1'b0;
			end
		endcase
		if (req_q.func == `MBA_FC_READ || req_q.func == `MBA_FC_RDWR) begin
			cnt_bad_c = cnt_bad(r_cnt_c);
			addr_bad_c = range_bad(req_q.rd_start, r_cnt_c) || asm_bad(req_q.rd_start);
		end
		if (w_cnt_c != 8'h00 || req_q.func == `MBA_FC_WRITEN || req_q.func == `MBA_FC_RDWR) begin
			cnt_bad_c = cnt_bad_c || cnt_bad(w_cnt_c);
			addr_bad_c = addr_bad_c || range_bad(req_q.wr_start, w_cnt_c) || asm_bad(req_q.wr_start);
		end
		exc_c = !fc_ok_c || cnt_bad_c || addr_bad_c;
		if (!fc_ok_c) begin
			exc_code_c = `MBA_EXC_FUNC;
		end else if (cnt_bad_c) begin
			exc_code_c = `MBA_EXC_VAL;
		end else if (addr_bad_c) begin
			exc_code_c = `MBA_EXC_ADDR;
		end else begin
			exc_code_c = `MBA_EXC_NONE;
		end
	end

	// One-based register number to zero-based array index
	assign wphys_c = phys(req_q.wr_start + {8'h00, idx_q});
	assign waddr_c = AW'(wphys_c - `MBA_REG_ONE);
	assign raddr_c = AW'(phys(req_q.rd_start + {8'h00, idx_q}) - `MBA_REG_ONE);

	assign req_ready  = (state_q == mba_pkg::MBA_ST_IDLE);
	assign wr_ready   = (state_q == mba_pkg::MBA_ST_WRITE);
	assign resp_valid = (state_q == mba_pkg::MBA_ST_RESP);
	assign rd_valid   = rd_valid_q;
	assign rd_data    = rd_data_q;
	assign resp       = resp_q;
	assign handover_pulse = ho_q;
	assign wr_fire    = wr_ready && wr_valid;
	assign rd_fire    = (state_q == mba_pkg::MBA_ST_READ) && (!rd_valid_q || rd_ready);

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			state_q <= mba_pkg::MBA_ST_IDLE;
			idx_q   <= 8'h00;
			w_cnt_q <= 8'h00;
			r_cnt_q <= 8'h00;
		end else begin
			case (state_q)
				mba_pkg::MBA_ST_IDLE: begin
					if (req_valid) begin
						state_q <= mba_pkg::MBA_ST_CHECK;
					end
				end
				mba_pkg::MBA_ST_CHECK: begin
					idx_q   <= 8'h00;
					w_cnt_q <= w_cnt_c;
					r_cnt_q <= r_cnt_c;
					if (exc_c) begin
						state_q <= mba_pkg::MBA_ST_RESP;
					end else if (w_cnt_c != 8'h00) begin
						state_q <= mba_pkg::MBA_ST_WRITE;
					end else begin
						state_q <= mba_pkg::MBA_ST_READ;
					end
				end
				mba_pkg::MBA_ST_WRITE: begin
					if (wr_valid) begin
						if (idx_q == w_cnt_q - 8'h01) begin
							idx_q <= 8'h00;
							state_q <= (r_cnt_q != 8'h00) ? mba_pkg::MBA_ST_READ : mba_pkg::MBA_ST_RESP;
						end else begin
							idx_q <= idx_q + 8'h01;
						end
					end
				end
				mba_pkg::MBA_ST_READ: begin
					if (rd_fire) begin
						if (idx_q != r_cnt_q) begin
							idx_q <= idx_q + 8'h01;
						end else begin
							state_q <= mba_pkg::MBA_ST_RESP;
						end
					end
				end
				mba_pkg::MBA_ST_RESP: begin
					if (resp_ready) begin
						state_q <= mba_pkg::MBA_ST_IDLE;
					end
				end
				default: begin
					state_q <= mba_pkg::MBA_ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			req_q  <= '0;
			resp_q <= '0;
		end else begin
			if (req_ready && req_valid) begin
				req_q <= req;
			end
			if (state_q == mba_pkg::MBA_ST_CHECK) begin
				resp_q.exception <= exc_c;
				resp_q.func      <= req_q.func;
				resp_q.exc_code  <= exc_code_c;
			end
		end
	end

	// Array has no reset; contents persist as configuration
	always_ff @(posedge sys_clk) begin
		if (wr_fire) begin
			mem[waddr_c] <= wr_data;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			rd_valid_q <= 1'b0;
			rd_data_q  <= 16'h0000;
		end else if (rd_fire) begin
			rd_valid_q <= (idx_q != r_cnt_q);
			if (idx_q != r_cnt_q) begin
				rd_data_q <= mem[raddr_c];
			end
		end
	end

	// Downstream logic watches the mailbox for the hand-over value
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			ho_q <= 1'b0;
		end else begin
			ho_q <= wr_fire && (wphys_c == `MBA_HO_ADDR) && (wr_data == `MBA_HO_VAL);
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_b);

	sequence s_check_ok;
		state_q == mba_pkg::MBA_ST_CHECK && !exc_c;
	endsequence

	sequence s_wr_last;
		wr_fire && idx_q == w_cnt_q - 8'h01;
	endsequence

	AST_READ_STARTS: assert property (s_check_ok and (w_cnt_c == 8'h00) |-> ##[1:2] rd_valid)
		else $error("read did not produce data");
	AST_SINGLE_WRITE: assert property (s_check_ok and (req_q.func == `MBA_FC_WRITE1) |=>
		state_q == mba_pkg::MBA_ST_WRITE && w_cnt_q == 8'h01)
		else $error("single write not one word");
	AST_WRITE_ENDS: assert property (s_wr_last |=> state_q != mba_pkg::MBA_ST_WRITE)
		else $error("write did not end after last word");
	AST_RDWR_ORDER: assert property (s_check_ok and (req_q.func == `MBA_FC_RDWR) |=>
		state_q == mba_pkg::MBA_ST_WRITE && r_cnt_q == req_q.rd_cnt)
		else $error("combined request not write first");
	AST_STORE: assert property (wr_fire |=> mem[$past(waddr_c)] == $past(wr_data))
		else $error("write not stored");
	AST_ASM_START: assert property (state_q == mba_pkg::MBA_ST_CHECK && fc_ok_c && !cnt_bad_c &&
		req_q.func == `MBA_FC_READ && asm_bad(req_q.rd_start) |=>
		resp_q.exception && resp_q.exc_code == `MBA_EXC_ADDR)
		else $error("mid-assembly start not refused");
	AST_ZERO_REG: assert property (state_q == mba_pkg::MBA_ST_CHECK && fc_ok_c && !cnt_bad_c &&
		req_q.func == `MBA_FC_READ && req_q.rd_start == 16'h0000 |=> resp_q.exc_code == `MBA_EXC_ADDR)
		else $error("register zero accepted");
	AST_HANDOVER: assert property (wr_fire && wphys_c == `MBA_HO_ADDR && wr_data == `MBA_HO_VAL |=>
		handover_pulse ##1 !handover_pulse)
		else $error("hand-over not signalled");
	AST_ONE_RESP: assert property (resp_valid && resp_ready |=> !resp_valid [*2])
		else $error("second response for one request");
	AST_OVERSIZE: assert property (state_q == mba_pkg::MBA_ST_CHECK && fc_ok_c && cnt_bad_c |=>
		state_q == mba_pkg::MBA_ST_RESP && resp_q.exc_code == `MBA_EXC_VAL && !wr_ready)
		else $error("oversized count not refused");

endmodule : mba_access
`default_nettype wire

// ---- rtl/mba_cfg.svh ----
`ifndef MBA_CFG_SVH
`define MBA_CFG_SVH

// Supported function codes
`define MBA_FC_READ        8'h03
`define MBA_FC_WRITE1      8'h06
`define MBA_FC_WRITEN      8'h10
`define MBA_FC_RDWR        8'h17

// Largest register count per instruction (45)
`define MBA_MAX_CNT        8'h2D

// Exception codes
`define MBA_EXC_NONE       8'h00
`define MBA_EXC_FUNC       8'h01
`define MBA_EXC_ADDR       8'h02
`define MBA_EXC_VAL        8'h03

// One-based register numbering
`define MBA_REG_ONE        16'h0001

// Input assembly: window at 1500, sourced from scattered registers
`define MBA_IN_BASE        16'h05DC
`define MBA_IN_LEN         16'h0014
`define MBA_IN_SRC         16'h0074
`define MBA_IN_STRIDE      16'h0002

// Output assembly window and its sources
`define MBA_OUT_BASE       16'h0640
`define MBA_OUT_LEN        16'h0014
`define MBA_OUT_SRC        16'h0100
`define MBA_OUT_STRIDE     16'h0002

// Hand-over mailbox written by the upstream neighbour
`define MBA_HO_ADDR        16'h0020
`define MBA_HO_VAL         16'h0001

// Register array depth
`define MBA_DEPTH          2048

`endif

// ---- rtl/mba_pkg.sv ----
`default_nettype none
package mba_pkg;

	typedef enum logic [1:0] {
		MBA_PROTO_MODBUS = 2'h0,
		MBA_PROTO_ENIP   = 2'h1,
		MBA_PROTO_PNIO   = 2'h2
	} mba_proto_t;

	typedef struct packed {
		mba_proto_t  proto;
		logic [7:0]  func;
		logic [15:0] rd_start;
		logic [7:0]  rd_cnt;
		logic [15:0] wr_start;
		logic [7:0]  wr_cnt;
	} mba_req_t;

	typedef struct packed {
		logic        exception;
		logic [7:0]  func;
		logic [7:0]  exc_code;
	} mba_resp_t;

	typedef enum logic [4:0] {
		MBA_ST_IDLE  = 5'h01,
		MBA_ST_CHECK = 5'h02,
		MBA_ST_WRITE = 5'h04,
		MBA_ST_READ  = 5'h08,
		MBA_ST_RESP  = 5'h10
	} mba_state_t;

endpackage : mba_pkg
`default_nettype wire

// ---- sim/mba_client_model.sv ----
`default_nettype none
module mba_client_model (
	input  wire logic sys_clk,
	input  wire logic rst_b,
	input  wire logic slow,
	output logic      rd_ready,
	output logic      resp_ready
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [2:0] tick_q;
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			tick_q <= 3'h0;
		end else begin
			tick_q <= tick_q + 3'h1;
		end
	end
	// Slow client stalls read words and responses on different cycles
	assign rd_ready   = !slow || tick_q == 3'h0;
	assign resp_ready = !slow || tick_q == 3'h3;
endmodule : mba_client_model
`default_nettype wire

// ---- sim/modbus_assembly_access_tb.sv ----
`include "mba_cfg.svh"
`default_nettype none
module modbus_assembly_access_tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [7:0] RD = `MBA_FC_READ;
	localparam logic [7:0] W1 = `MBA_FC_WRITE1;
	localparam logic [7:0] WN = `MBA_FC_WRITEN;
	localparam logic [7:0] RW = `MBA_FC_RDWR;
	localparam logic [7:0] OK = `MBA_EXC_NONE;
	logic               sys_clk   = 1'b0;
	logic               rst_b     = 1'b0;
	logic               req_valid = 1'b0;
	logic               wr_valid  = 1'b0;
	logic               slow      = 1'b0;
	logic [15:0]        wr_data   = 16'h0000;
	mba_pkg::mba_req_t  req       = '0;
	mba_pkg::mba_resp_t resp;
	logic [15:0]        rd_data;
	logic               req_ready, wr_ready, rd_valid, rd_ready, resp_valid, resp_ready, handover_pulse;
	logic [15:0]        mem [1:2048];
	logic [15:0]        exp_rd [$];
	logic [16:0]        exp_resp [$];
	logic [31:0]        seed      = 32'hF0479C52;
	int                 failures  = 0;
	int                 n_checks  = 0;
	int                 exp_ho    = 0;
	int                 n_ho      = 0;

	always #50 sys_clk = ~sys_clk;

	mba_access #(.DEPTH(2048)) u_dut (.sys_clk, .rst_b, .req_valid, .req_ready, .req, .wr_valid, .wr_ready,
		.wr_data, .rd_valid, .rd_ready, .rd_data, .resp_valid, .resp_ready, .resp, .handover_pulse);
	mba_client_model u_client (.sys_clk, .rst_b, .slow, .rd_ready, .resp_ready);

	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs

	// Assembly windows land on every second scattered register
	function automatic int fold(input int a);
		if (a >= `MBA_IN_BASE && a < `MBA_IN_BASE + `MBA_IN_LEN) return `MBA_IN_SRC + 2 * (a - `MBA_IN_BASE);
		if (a >= `MBA_OUT_BASE && a < `MBA_OUT_BASE + `MBA_OUT_LEN) return `MBA_OUT_SRC + 2 * (a - `MBA_OUT_BASE);
		return a;
	endfunction : fold

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic summarize();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : summarize

	task automatic op(input logic [1:0] pr, input logic [7:0] fc, input int rs, rc, ws, wc,
		input logic [7:0] exc, input bit fx = 1'b0);
		int          nw;
		int          nr;
		bit          ok;
		logic [15:0] d;
		nw = (exc != OK || fc == RD) ? 0 : (fc == W1 ? 1 : wc);
		nr = (exc == OK && (fc == RD || fc == RW)) ? rc : 0;
		@(posedge sys_clk);
		exp_resp.push_back({exc != OK, fc, exc});
		req_valid <= 1'b1;
		req <= '{mba_pkg::mba_proto_t'(pr), fc, rs[15:0], rc[7:0], ws[15:0], wc[7:0]};
		do begin
			@(negedge sys_clk);
			ok = req_ready;
			@(posedge sys_clk);
		end while (!ok);
		req_valid <= 1'b0;
		for (int k = 0; k < nw; k++) begin
			d = fx ? `MBA_HO_VAL : 16'(xs());
			mem[fold(ws + k)] = d;
			if (fold(ws + k) == `MBA_HO_ADDR && d == `MBA_HO_VAL) exp_ho++;
			wr_data <= d;
			wr_valid <= 1'b1;
			do begin
				@(negedge sys_clk);
				ok = wr_ready;
				@(posedge sys_clk);
			end while (!ok);
		end
		wr_valid <= 1'b0;
		for (int k = 0; k < nr; k++) exp_rd.push_back(mem[fold(rs + k)]);
	endtask : op

	// Results sampled mid-cycle, clear of the edge that moves them
	always @(negedge sys_clk) begin
		if (rst_b && rd_valid && rd_ready) begin
			if (exp_rd.size() == 0) chk("rd_extra", 1, 0);
			else chk("rd_data", rd_data, exp_rd.pop_front());
		end
		if (rst_b && resp_valid && resp_ready) begin
			if (exp_resp.size() == 0) chk("resp_extra", 1, 0);
			else chk("resp", resp, exp_resp.pop_front());
		end
		if (handover_pulse) n_ho++;
	end

	initial begin
		fork
			begin
				#2000000;
				failures++;
				summarize();
			end
		join_none
		repeat (16) @(posedge sys_clk);
		rst_b <= 1'b1;
		op(0, WN, 0, 0, 1, 45, OK);
		op(0, RD, 1, 45, 0, 0, OK);
		op(0, W1, 0, 0, 32, 1, OK, 1'b1);
		op(0, WN, 0, 0, 116, 39, OK);
		op(1, RD, 1500, 20, 0, 0, OK);
		op(2, RW, 1600, 20, 1600, 20, OK);
		slow <= 1'b1;
		op(0, RD, 1504, 5, 0, 0, `MBA_EXC_ADDR);
		op(0, WN, 0, 0, 1601, 2, `MBA_EXC_ADDR);
		op(0, RD, 0, 1, 0, 0, `MBA_EXC_ADDR);
		op(0, RD, 2048, 2, 0, 0, `MBA_EXC_ADDR);
		op(0, RD, 1, 46, 0, 0, `MBA_EXC_VAL);
		op(0, WN, 0, 0, 1, 46, `MBA_EXC_VAL);
		op(0, RW, 1, 0, 1, 1, `MBA_EXC_VAL);
		op(0, 8'h05, 1, 1, 0, 0, `MBA_EXC_FUNC);
		op(3, RD, 1, 1, 0, 0, `MBA_EXC_FUNC);
		op(0, RW, 1, 45, 46, 45, OK);
		for (int i = 0; i < 2000 && exp_resp.size() + exp_rd.size() > 0; i++) @(posedge sys_clk);
		repeat (8) @(posedge sys_clk);
		chk("handover", n_ho, exp_ho);
		chk("pending", exp_resp.size() + exp_rd.size(), 0);
		summarize();
	end
endmodule : modbus_assembly_access_tb
`default_nettype wire
